// >>> core/pss_consts.vh
// Constants for the power and system settings register bank
`ifndef PSS_CONSTS_VH
`define PSS_CONSTS_VH

// Register offsets on the host access port
`define PSS_ADDR_POWER_SYSTEM 8'h80
`define PSS_ADDR_SENSE_EVENT 8'h81
`define PSS_ADDR_CHAN_ENABLE 8'h82

// Reset values
`define PSS_RST_POWER_SYSTEM 16'h0000
`define PSS_RST_SENSE_EVENT 16'h0000
`define PSS_RST_CHAN_ENABLE 16'h0000

// Power/system config: byte at offset 0 sits in bits 7:0, offset 1 in bits 15:8
`define PSS_BIT_OSC_SLOW 7
`define PSS_BIT_WAKE_ULP 6
`define PSS_BIT_AUTO_OFF 5
`define PSS_MODE_HI 4
`define PSS_MODE_LO 3
`define PSS_ULP_RATE_HI 2
`define PSS_ULP_RATE_LO 0
`define PSS_BIT_RESERVED 15
`define PSS_BIT_ADV_TUNE_STREAM 14
`define PSS_BIT_EVENT_MODE 13
`define PSS_BIT_ADV_NP_STREAM 12
`define PSS_BIT_CMD_EXIT_WIN 11
`define PSS_BIT_CMD_RETUNE 10
`define PSS_BIT_CMD_ACK_RESET 8
// Command and reserved bits never hold a value
`define PSS_VOLATILE_MASK 16'h8d00

// Sensing/event config fields
`define PSS_BIT_BAND_CHECK_OFF 7
`define PSS_LTB_RATE_HI 6
`define PSS_LTB_RATE_LO 4
`define PSS_BIT_LP_ONLY_TUNE 3
`define PSS_PIN3_SEL_HI 2
`define PSS_PIN3_SEL_LO 0
`define PSS_EVT_MASK_HI 15
`define PSS_EVT_MASK_LO 8

// Power mode codes
`define PSS_MODE_NORMAL 2'b00
`define PSS_MODE_LOW 2'b01
`define PSS_MODE_ULTRA_LOW 2'b10
`define PSS_MODE_HALT 2'b11

// Update period, in wake-channel scans, of the other channels in ultra-low power
`define PSS_ULP_PER_0 8'd8
`define PSS_ULP_PER_1 8'd13
`define PSS_ULP_PER_2 8'd26
`define PSS_ULP_PER_3 8'd54
`define PSS_ULP_PER_4 8'd85
`define PSS_ULP_PER_5 8'd135
`define PSS_ULP_PER_6 8'd170
`define PSS_ULP_PER_7 8'd255

// Idle scans before automatic step down
`define PSS_IDLE_NP_TO_LP 8'd32
`define PSS_IDLE_LP_TO_ULP 8'd64

`endif

// >>> core/pss_period_tick.v
// Counts step pulses and emits one tick every period steps
`timescale 1ns/100ps
`default_nettype none
module pss_period_tick (
  // Clock and reset
  input wire clk_in,
  input wire arst_n_in,
  // Control
  input wire step_in,
  input wire clear_in,
  input wire [7:0] period_in,
  // Result
  output reg tick_out
);
  reg [7:0] count_q;
  wire [7:0] count_next;

  assign count_next = count_q + 8'h01;

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count_q <= 8'h00;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (clear_in) begin
        count_q <= 8'h00;
      end else if (step_in) begin
        // A period of zero behaves as one so the tick never stalls
        if (count_next >= period_in) begin
          count_q <= 8'h00;
          tick_out <= 1'b1;
        end else begin
          count_q <= count_next;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> core/pss_power_and_system_settings_regs.v
// Power and system settings register bank with power-mode control
`timescale 1ns/100ps
`default_nettype none
`include "pss_consts.vh"
module pss_power_and_system_settings_regs (
  // Clock and reset
  input wire clk_in,
  input wire arst_n_in,
  // Register access from the serial interface
  input wire [7:0] host_addr_in,
  input wire [15:0] host_wdata_in,
  input wire [1:0] host_be_in,
  input wire host_wr_in,
  input wire host_rd_in,
  output reg [15:0] host_rdata_out,
  output reg host_rvalid_out,
  // Sensing engine status
  input wire scan_done_in,
  input wire wake_scan_done_in,
  input wire activity_in,
  input wire tuning_busy_in,
  input wire [7:0] tune_select_in,
  input wire [7:0] touch_in,
  // Clock and power control
  output reg osc_fast_out,
  output reg [1:0] power_mode_out,
  output reg auto_switch_out,
  output reg wake_sense_ulp_out,
  // Channel pacing
  output wire other_update_out,
  output wire long_term_baseline_tick_out,
  // Reporting and commands
  output reg streaming_out,
  output reg retune_command_out,
  output reg [7:0] retune_sel_out,
  output reg reset_shown_out,
  output reg exit_window_out,
  // Tuning options
  output reg band_check_en_out,
  output reg lp_only_tune_out,
  // Third output pin and masks
  output reg third_output_pin_out,
  output reg [7:0] event_mask_out,
  output reg [15:0] channel_enable_out
);
  reg [15:0] power_system_config_q;
  reg [15:0] sensing_and_event_config_q;
  reg [15:0] channel_enable_map_q;
  reg [1:0] mode_q;
  reg [1:0] mode_d;
  reg [7:0] idle_q;
  reg [7:0] idle_d;
  reg [15:0] pwr_d;
  reg [15:0] sense_d;
  reg [15:0] chan_d;
  reg [15:0] rdata_d;
  reg stream_d;
  wire wr_pwr;
  wire [2:0] ulp_code;
  wire [2:0] ltb_code;
  wire [2:0] pin3_sel;
  wire other_step;
  wire ulp_tick;

  // Address decode, shared by the write and read paths
  function [2:0] reg_hit;
    input [7:0] addr;
    begin
      reg_hit = {addr == `PSS_ADDR_CHAN_ENABLE,
                 addr == `PSS_ADDR_SENSE_EVENT,
                 addr == `PSS_ADDR_POWER_SYSTEM};
    end
  endfunction

  // Byte-lane merge of a write into a stored word
  function [15:0] merge;
    input [15:0] old;
    input [15:0] wdata;
    input [1:0] be;
    begin
      merge = {be[1] ? wdata[15:8] : old[15:8], be[0] ? wdata[7:0] : old[7:0]};
    end
  endfunction

  // Other-channel period table in ultra-low power
  function [7:0] ulp_period;
    input [2:0] code;
    begin
      case (code)
        3'h0: ulp_period = `PSS_ULP_PER_0;
        3'h1: ulp_period = `PSS_ULP_PER_1;
        3'h2: ulp_period = `PSS_ULP_PER_2;
        3'h3: ulp_period = `PSS_ULP_PER_3;
        3'h4: ulp_period = `PSS_ULP_PER_4;
        3'h5: ulp_period = `PSS_ULP_PER_5;
        3'h6: ulp_period = `PSS_ULP_PER_6;
        default: ulp_period = `PSS_ULP_PER_7;
      endcase
    end
  endfunction

  assign wr_pwr = host_wr_in && reg_hit(host_addr_in) == 3'b001;
  assign ulp_code = power_system_config_q[`PSS_ULP_RATE_HI:`PSS_ULP_RATE_LO];
  assign ltb_code = sensing_and_event_config_q[`PSS_LTB_RATE_HI:`PSS_LTB_RATE_LO];
  assign pin3_sel = sensing_and_event_config_q[`PSS_PIN3_SEL_HI:`PSS_PIN3_SEL_LO];

  // Register write path; command and reserved bits are not stored
  always @* begin
    pwr_d = power_system_config_q;
    sense_d = sensing_and_event_config_q;
    chan_d = channel_enable_map_q;
    if (host_wr_in) begin
      case (reg_hit(host_addr_in))
        3'b001: pwr_d = merge(power_system_config_q, host_wdata_in, host_be_in)
                        & ~`PSS_VOLATILE_MASK;
        3'b010: sense_d = merge(sensing_and_event_config_q, host_wdata_in, host_be_in);
        3'b100: chan_d = merge(channel_enable_map_q, host_wdata_in, host_be_in);
        default: pwr_d = power_system_config_q;
      endcase
    end
  end

  // Read path; unmapped addresses read as zero, command bits read as zero
  always @* begin
    case (reg_hit(host_addr_in))
      3'b001: rdata_d = power_system_config_q;
      3'b010: rdata_d = sensing_and_event_config_q;
      3'b100: rdata_d = channel_enable_map_q;
      default: rdata_d = 16'h0000;
    endcase
  end

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      power_system_config_q <= `PSS_RST_POWER_SYSTEM;
      sensing_and_event_config_q <= `PSS_RST_SENSE_EVENT;
      channel_enable_map_q <= `PSS_RST_CHAN_ENABLE;
      host_rdata_out <= 16'h0000;
      host_rvalid_out <= 1'b0;
    end else begin
      power_system_config_q <= pwr_d;
      sensing_and_event_config_q <= sense_d;
      channel_enable_map_q <= chan_d;
      host_rvalid_out <= host_rd_in;
      if (host_rd_in) begin
        host_rdata_out <= rdata_d;
      end
    end
  end

  // Command pulses and the reset-flag clear, one cycle after the write that carries them
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      retune_command_out <= 1'b0;
      retune_sel_out <= 8'h00;
      exit_window_out <= 1'b0;
      reset_shown_out <= 1'b1;
    end else begin
      retune_command_out <= 1'b0;
      exit_window_out <= 1'b0;
      if (wr_pwr && host_be_in[1] && host_wdata_in[`PSS_BIT_CMD_RETUNE]) begin
        retune_command_out <= 1'b1;
        // Channels outside the selection byte are left alone
        retune_sel_out <= tune_select_in;
      end
      if (wr_pwr && host_be_in[1] && host_wdata_in[`PSS_BIT_CMD_EXIT_WIN]) begin
        exit_window_out <= 1'b1;
      end
      // The flag is only ever set by reset, so nothing can race the clear
      if (wr_pwr && host_be_in[1] && host_wdata_in[`PSS_BIT_CMD_ACK_RESET]) begin
        reset_shown_out <= 1'b0;
      end
    end
  end

  // Power mode: automatic stepping down on idle scans, or the manual field
  always @* begin
    mode_d = mode_q;
    idle_d = idle_q;
    if (power_system_config_q[`PSS_BIT_AUTO_OFF]) begin
      mode_d = power_system_config_q[`PSS_MODE_HI:`PSS_MODE_LO];
      idle_d = 8'h00;
    end else begin
      case (mode_q)
        `PSS_MODE_NORMAL: begin
          if (activity_in) begin
            idle_d = 8'h00;
          end else if (scan_done_in) begin
            if (idle_q + 8'h01 >= `PSS_IDLE_NP_TO_LP) begin
              mode_d = `PSS_MODE_LOW;
              idle_d = 8'h00;
            end else begin
              idle_d = idle_q + 8'h01;
            end
          end
        end
        `PSS_MODE_LOW: begin
          if (activity_in) begin
            mode_d = `PSS_MODE_NORMAL;
            idle_d = 8'h00;
          end else if (scan_done_in) begin
            if (idle_q + 8'h01 >= `PSS_IDLE_LP_TO_ULP) begin
              mode_d = `PSS_MODE_ULTRA_LOW;
              idle_d = 8'h00;
            end else begin
              idle_d = idle_q + 8'h01;
            end
          end
        end
        `PSS_MODE_ULTRA_LOW: begin
          if (activity_in) begin
            mode_d = `PSS_MODE_NORMAL;
            idle_d = 8'h00;
          end
        end
        default: begin
          // Halt is only a manual choice; automatic control resumes in normal power
          mode_d = `PSS_MODE_NORMAL;
          idle_d = 8'h00;
        end
      endcase
    end
  end

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_q <= `PSS_MODE_NORMAL;
      idle_q <= 8'h00;
    end else begin
      mode_q <= mode_d;
      idle_q <= idle_d;
    end
  end

  // Reporting style
  always @* begin
    if (tuning_busy_in && power_system_config_q[`PSS_BIT_ADV_TUNE_STREAM]) begin
      stream_d = 1'b1;
    end else if (power_system_config_q[`PSS_BIT_ADV_NP_STREAM]) begin
      stream_d = (mode_q == `PSS_MODE_NORMAL);
    end else begin
      stream_d = ~power_system_config_q[`PSS_BIT_EVENT_MODE];
    end
  end

  // Configuration outputs, all from flops
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      osc_fast_out <= 1'b1;
      power_mode_out <= `PSS_MODE_NORMAL;
      auto_switch_out <= 1'b1;
      wake_sense_ulp_out <= 1'b0;
      streaming_out <= 1'b1;
      band_check_en_out <= 1'b1;
      lp_only_tune_out <= 1'b0;
      third_output_pin_out <= 1'b0;
      event_mask_out <= 8'h00;
      channel_enable_out <= 16'h0000;
    end else begin
      osc_fast_out <= ~power_system_config_q[`PSS_BIT_OSC_SLOW];
      power_mode_out <= mode_q;
      auto_switch_out <= ~power_system_config_q[`PSS_BIT_AUTO_OFF];
      wake_sense_ulp_out <= power_system_config_q[`PSS_BIT_WAKE_ULP];
      streaming_out <= stream_d;
      band_check_en_out <= ~sensing_and_event_config_q[`PSS_BIT_BAND_CHECK_OFF];
      lp_only_tune_out <= sensing_and_event_config_q[`PSS_BIT_LP_ONLY_TUNE];
      // Selector zero leaves the pin inactive
      third_output_pin_out <= (pin3_sel != 3'h0) && touch_in[pin3_sel];
      event_mask_out <= sensing_and_event_config_q[`PSS_EVT_MASK_HI:`PSS_EVT_MASK_LO];
      channel_enable_out <= channel_enable_map_q;
    end
  end

  // Other channels follow the wake scans only in ultra-low power
  pss_period_tick u_ulp_pacer (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .step_in(wake_scan_done_in),
    .clear_in(mode_q != `PSS_MODE_ULTRA_LOW),
    .period_in(ulp_period(ulp_code)),
    .tick_out(ulp_tick)
  );

  assign other_step = (mode_q == `PSS_MODE_ULTRA_LOW) ? ulp_tick : scan_done_in;
  assign other_update_out = other_step;

  // Baseline update every two to the code scans
  pss_period_tick u_ltb_pacer (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .step_in(scan_done_in),
    .clear_in(1'b0),
    .period_in(8'h01 << ltb_code),
    .tick_out(long_term_baseline_tick_out)
  );

endmodule
`default_nettype wire

// >>> verification/pss_regs_props.sv
// Checker bound to the power and system settings register bank
`timescale 1ns/100ps
`default_nettype none
module pss_regs_props (
  // Clock and reset
  input wire clk_in,
  input wire arst_n_in,
  // Register access
  input wire [7:0] host_addr_in,
  input wire [15:0] host_wdata_in,
  input wire [1:0] host_be_in,
  input wire host_wr_in,
  input wire [7:0] tune_select_in,
  // Observed outputs
  input wire osc_fast_out,
  input wire [1:0] power_mode_out,
  input wire auto_switch_out,
  input wire retune_command_out,
  input wire [7:0] retune_sel_out,
  input wire reset_shown_out,
  input wire exit_window_out,
  input wire third_output_pin_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  wire lo80 = host_wr_in && host_be_in[0] && host_addr_in == 8'h80;
  wire hi80 = host_wr_in && host_be_in[1] && host_addr_in == 8'h80;
  wire lo81 = host_wr_in && host_be_in[0] && host_addr_in == 8'h81;
  osc_select_a: assert property (
    lo80 |-> ##2 osc_fast_out == !$past(host_wdata_in[7], 2)) else $error("osc select");
  auto_switch_a: assert property (
    lo80 |-> ##2 auto_switch_out == !$past(host_wdata_in[5], 2)) else $error("auto switch");
  // The mode register sits between the field and the output, so this one lags an edge more
  manual_mode_a: assert property (
    lo80 && host_wdata_in[5] |-> ##3 power_mode_out == $past(host_wdata_in[4:3], 3))
    else $error("manual mode");
  retune_pulse_a: assert property (
    hi80 && host_wdata_in[10] |=> retune_command_out && retune_sel_out == $past(tune_select_in))
    else $error("retune pulse");
  retune_once_a: assert property (
    retune_command_out && !(hi80 && host_wdata_in[10]) |=> !retune_command_out)
    else $error("retune stuck");
  ack_reset_a: assert property (
    hi80 && host_wdata_in[8] |=> !reset_shown_out) else $error("ack reset");
  flag_sticky_a: assert property (
    !reset_shown_out |=> !reset_shown_out) else $error("reset flag set");
  exit_window_a: assert property (
    hi80 && host_wdata_in[11] |=> exit_window_out) else $error("exit window");
  pin3_none_a: assert property (
    lo81 && host_wdata_in[2:0] == 3'b000 |-> ##2 !third_output_pin_out) else $error("pin3 none");
  cover property (hi80 && host_wdata_in[10]);
  cover property (lo80 && host_wdata_in[5]);
  cover property (third_output_pin_out);
endmodule
bind pss_power_and_system_settings_regs pss_regs_props pss_regs_props_inst (
  .clk_in(clk_in),
  .arst_n_in(arst_n_in),
  .host_addr_in(host_addr_in),
  .host_wdata_in(host_wdata_in),
  .host_be_in(host_be_in),
  .host_wr_in(host_wr_in),
  .tune_select_in(tune_select_in),
  .osc_fast_out(osc_fast_out),
  .power_mode_out(power_mode_out),
  .auto_switch_out(auto_switch_out),
  .retune_command_out(retune_command_out),
  .retune_sel_out(retune_sel_out),
  .reset_shown_out(reset_shown_out),
  .exit_window_out(exit_window_out),
  .third_output_pin_out(third_output_pin_out)
);
`default_nettype wire

// >>> verification/pss_host_model.sv
// Host controller model driving the register access port
`timescale 1ns/100ps
`default_nettype none
module pss_host_model (
  // Clock
  input wire clk_in,
  // Requests
  output logic [7:0] addr_out,
  output logic [15:0] wdata_out,
  output logic [1:0] be_out,
  output logic wr_out,
  output logic rd_out,
  // Answers
  input wire [15:0] rdata_in,
  input wire rvalid_in
);
  initial begin
    addr_out = 8'h00;
    wdata_out = 16'h0000;
    be_out = 2'b00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // Released lines flip so a stale value never passes for a held request
  task automatic idle();
    addr_out = ~addr_out;
    wdata_out = ~wdata_out;
    be_out = ~be_out;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] b);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    be_out = b;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    idle();
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    d = rdata_in;
    v = rvalid_in;
    rd_out = 1'b0;
    idle();
  endtask
endmodule
`default_nettype wire

// >>> verification/test_power_and_system_settings_regs.sv
// Self-checking bench for the power and system settings register bank
`timescale 1ns/100ps
`default_nettype none
module test_power_and_system_settings_regs;
  logic clk_in = 1'b0, arst_n_in = 1'b0, scan_done_in = 1'b0, wake_scan_done_in = 1'b0;
  logic activity_in = 1'b0, tuning_busy_in = 1'b0, v;
  logic [7:0] tune_select_in = 8'h00, touch_in = 8'h00;
  logic [15:0] rv;
  logic [15:0] sw [5] = '{16'h2020, 16'h0020, 16'h6020, 16'h3020, 16'h1028};
  logic [4:0] se = 5'b01110;
  wire [7:0] host_addr_in, retune_sel_out, event_mask_out;
  wire [15:0] host_wdata_in, host_rdata_out, channel_enable_out;
  wire [1:0] host_be_in, power_mode_out;
  wire host_wr_in, host_rd_in, host_rvalid_out, osc_fast_out, auto_switch_out;
  wire wake_sense_ulp_out, other_update_out, long_term_baseline_tick_out, streaming_out;
  wire retune_command_out, reset_shown_out, exit_window_out, band_check_en_out;
  wire lp_only_tune_out, third_output_pin_out;
  int mismatches = 0, compares = 0, nt, nu, i, j;
  pss_power_and_system_settings_regs pss_power_and_system_settings_regs_inst (
    .clk_in(clk_in), .arst_n_in(arst_n_in),
    .host_addr_in(host_addr_in), .host_wdata_in(host_wdata_in), .host_be_in(host_be_in),
    .host_wr_in(host_wr_in), .host_rd_in(host_rd_in), .host_rdata_out(host_rdata_out),
    .host_rvalid_out(host_rvalid_out), .scan_done_in(scan_done_in),
    .wake_scan_done_in(wake_scan_done_in), .activity_in(activity_in),
    .tuning_busy_in(tuning_busy_in), .tune_select_in(tune_select_in), .touch_in(touch_in),
    .osc_fast_out(osc_fast_out), .power_mode_out(power_mode_out),
    .auto_switch_out(auto_switch_out), .wake_sense_ulp_out(wake_sense_ulp_out),
    .other_update_out(other_update_out),
    .long_term_baseline_tick_out(long_term_baseline_tick_out),
    .streaming_out(streaming_out), .retune_command_out(retune_command_out),
    .retune_sel_out(retune_sel_out), .reset_shown_out(reset_shown_out),
    .exit_window_out(exit_window_out), .band_check_en_out(band_check_en_out),
    .lp_only_tune_out(lp_only_tune_out), .third_output_pin_out(third_output_pin_out),
    .event_mask_out(event_mask_out), .channel_enable_out(channel_enable_out));
  pss_host_model pss_host_model_inst (
    .clk_in(clk_in), .addr_out(host_addr_in), .wdata_out(host_wdata_in), .be_out(host_be_in),
    .wr_out(host_wr_in), .rd_out(host_rd_in), .rdata_in(host_rdata_out),
    .rvalid_in(host_rvalid_out));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    if (mismatches == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] b);
    pss_host_model_inst.wr(a, d, b);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    pss_host_model_inst.rd(a, rv, v);
    chk(v, 1'b1);
    chk(rv, e);
  endtask
  // Pulses one scan line n times, one idle cycle apart, counting the pacing outputs
  task automatic pulse(input int n, input bit w);
    nt = 0;
    nu = 0;
    for (i = 0; i < 2 * n + 3; i++) begin
      @(negedge clk_in);
      nt += long_term_baseline_tick_out;
      nu += other_update_out;
      scan_done_in = !w && i < 2 * n && i % 2 == 0;
      wake_scan_done_in = w && i < 2 * n && i % 2 == 0;
    end
  endtask
  initial forever #4 clk_in = ~clk_in;
  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    complete_run();
  end
  initial begin
    repeat (3) @(negedge clk_in);
    arst_n_in = 1'b1;
    chk(osc_fast_out, 1'b1);
    chk(auto_switch_out, 1'b1);
    chk(streaming_out, 1'b1);
    chk(band_check_en_out, 1'b1);
    chk(reset_shown_out, 1'b1);
    for (j = 0; j < 3; j++) rd(8'h80 + j[7:0], 16'h0000);
    pulse(32, 1'b0);
    chk(power_mode_out, 2'b01);
    chk(nt[15:0], 16'd32);
    chk(nu[15:0], 16'd32);
    activity_in = 1'b1;
    repeat (3) @(negedge clk_in);
    chk(power_mode_out, 2'b00);
    activity_in = 1'b0;
    for (j = 0; j < 4; j++) begin
      wr(8'h80, 16'h00a0 | 16'(j << 3), 2'b01);
      // Field to mode register to output takes two edges after the register
      repeat (2) @(negedge clk_in);
      chk(power_mode_out, j[1:0]);
      chk(osc_fast_out, 1'b0);
      chk(auto_switch_out, 1'b0);
    end
    for (j = 0; j < 2; j++) begin
      wr(8'h80, 16'h00f0 | 16'(2 * j), 2'b01);
      pulse(j ? 52 : 16, 1'b1);
      chk(nu[15:0], 16'd2);
      chk(wake_sense_ulp_out, 1'b1);
    end
    wr(8'h81, 16'h0030, 2'b01);
    pulse(16, 1'b0);
    chk(nt[15:0], 16'd2);
    tune_select_in = 8'h5a;
    wr(8'h80, 16'hff00, 2'b10);
    chk(retune_command_out, 1'b1);
    chk(retune_sel_out, 8'h5a);
    chk(exit_window_out, 1'b1);
    chk(reset_shown_out, 1'b0);
    @(negedge clk_in);
    chk(retune_command_out, 1'b0);
    rd(8'h80, 16'h72f2);
    for (j = 0; j < 5; j++) begin
      tuning_busy_in = j == 2;
      wr(8'h80, sw[j], 2'b11);
      repeat (2) @(negedge clk_in);
      chk(streaming_out, se[j]);
    end
    for (j = 0; j < 8; j++) begin
      touch_in = j ? 8'h01 << j : 8'hff;
      wr(8'h81, {8'ha5, 5'h11, j[2:0]}, 2'b11);
      repeat (2) @(negedge clk_in);
      chk(third_output_pin_out, j != 0);
      // Touch everywhere but the selected channel must leave the pin low
      touch_in = ~touch_in;
      repeat (2) @(negedge clk_in);
      chk(third_output_pin_out, 1'b0);
    end
    chk(band_check_en_out, 1'b0);
    rd(8'h81, 16'ha58f);
    chk(event_mask_out, 8'ha5);
    chk(lp_only_tune_out, 1'b1);
    wr(8'h82, 16'hc3e1, 2'b11);
    wr(8'h82, 16'h0000, 2'b00);
    rd(8'h82, 16'hc3e1);
    chk(channel_enable_out, 16'hc3e1);
    wr(8'h90, 16'hffff, 2'b11);
    rd(8'h90, 16'h0000);
    rd(8'h82, 16'hc3e1);
    // A second reset must raise the indicator again and clear the registers
    arst_n_in = 1'b0;
    @(negedge clk_in);
    arst_n_in = 1'b1;
    chk(reset_shown_out, 1'b1);
    chk(osc_fast_out, 1'b1);
    rd(8'h80, 16'h0000);
    rd(8'h82, 16'h0000);
    complete_run();
  end
endmodule
`default_nettype wire
